// File: rtl/atp_pkg.sv
/*
  Constants and carrier types for the A/D trigger timer pair.
  Assumes a 32-bit APB register bus and a single 250 MHz clock.
*/
package atp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_UNIT_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRESCALE    = 8'h04;
  localparam logic [7:0] OFS_MASTER_MODE = 8'h08;
  localparam logic [7:0] OFS_SLAVE_MODE  = 8'h0c;
  localparam logic [7:0] OFS_MASTER_DATA = 8'h10;
  localparam logic [7:0] OFS_SLAVE_DATA  = 8'h14;
  localparam logic [7:0] OFS_MASTER_CNT  = 8'h18;
  localparam logic [7:0] OFS_SLAVE_CNT   = 8'h1c;
  localparam logic [7:0] OFS_START_TRIG  = 8'h20;
  localparam logic [7:0] OFS_STOP_TRIG   = 8'h24;
  localparam logic [7:0] OFS_ENABLE_STAT = 8'h28;
  localparam logic [7:0] OFS_SLAVE_STAT  = 8'h2c;
  localparam logic [7:0] OFS_OUT_CTRL    = 8'h30;

  // Unit control fields
  localparam int BIT_POWER_EN   = 0;
  localparam int BIT_CLOCK_EN   = 1;
  // Mode fields
  localparam int BIT_START_INT  = 0;
  // Trigger and status fields
  localparam int BIT_MASTER     = 0;
  localparam int BIT_SLAVE      = 1;
  // Slave status fields
  localparam int BIT_UP_PHASE   = 0;
  localparam int BIT_HALTED     = 1;
  // Output control fields
  localparam int BIT_OUT_ENABLE = 0;
  localparam int BIT_OUT_LEVEL  = 1;
  localparam int BIT_PORT_DIR   = 2;
  localparam int BIT_PORT_LATCH = 3;

  // Field widths and reset values
  localparam int          PSC_SEL_W     = 4;
  localparam int          MODE_W        = 16;
  localparam logic [15:0] RST_DATA      = 16'h0000;
  localparam logic [15:0] SLAVE_HIT_VAL = 16'h0001;

  // Clock figures
  localparam int CLK_PERIOD_NS  = 4;
  localparam int APB_WAIT_CYC   = 1;

  // Pin carrier
  typedef struct packed {
    logic val;
    logic oe;
  } atp_pin_t;

  // Slave channel state, Gray coded along idle-load-run-halt
  typedef enum logic [1:0] {
    SLV_IDLE = 2'b00,
    SLV_LOAD = 2'b01,
    SLV_RUN  = 2'b11,
    SLV_HALT = 2'b10
  } atp_slv_state_t;

endpackage : atp_pkg

// File: rtl/atp_top.sv
/*
  Master/slave timer pair producing A/D conversion trigger pulses.
  Assumes an APB master on REF_CLK_I and software that programs the
  channels before starting them.
*/
// Notes on behaviour
// - Unit off: counting clock gated, channel register writes ignored.
// - Pin shows master level when port is output and latch is zero.
// - Start bits set both enable flags; trigger bits never read back.
// - Start interrupt on master only when start interrupt select is one.
// - Master loads data, counts down, at zero interrupts and reloads.
// - Slave loads data, counts down or up by master phase.
// - Slave count 0001h raises conversion trigger and halts.
// - Master interrupt in up phase reloads and restarts slave.
// - Counters and slave status readable without disturbing counting.
// - Stop bits clear enables and freeze both counters.
// - Stopped master keeps its level; pin then shows level bit.
// - Unit off resets timer logic, clears level, pin back to port.
// - Two master periods form one carrier: down then up.
// - With default level and start interrupt select one, output high in down, low in up phase.
// - New slave data takes effect at next carrier reload.
`timescale 1ns/10ps
module atp_top #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 16
) (
  // Clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              NRST_I,
  // APB slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // Timer events
  output logic                   MASTER_INT_O,
  output logic                   ADC_TRIG_O,
  // Master output pin
  output atp_pkg::atp_pin_t      MASTER_PIN_O
);

  // Elaboration check of widths
  if (CNT_W < 2 || CNT_W > 16 || PSC_W < 2 || PSC_W > 16) begin : g_bad_w
    $error("atp_top: unsupported CNT_W or PSC_W");
  end

  // Register state
  logic                  power_en_ff;
  logic                  clock_en_ff;
  logic [atp_pkg::PSC_SEL_W-1:0] psc_sel_ff;
  logic [atp_pkg::MODE_W-1:0]    mmode_ff;
  logic [atp_pkg::MODE_W-1:0]    smode_ff;
  logic [CNT_W-1:0]      mdata_ff;
  logic [CNT_W-1:0]      sdata_ff;
  logic                  out_en_ff;
  logic                  out_level_ff;
  logic                  port_dir_ff;
  logic                  port_latch_ff;
  // Bus state
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic [31:0]           prdata_ff;
  logic [31:0]           nxt_prdata;
  logic                  nxt_unmapped;
  // Counting state
  logic [PSC_W-1:0]      psc_cnt_ff;
  logic [CNT_W-1:0]      mcnt_ff;
  logic [CNT_W-1:0]      scnt_ff;
  logic                  m_en_ff;
  logic                  s_en_ff;
  logic                  up_phase_ff;
  atp_pkg::atp_slv_state_t slv_state_ff;
  logic                  mint_ff;
  logic                  trig_ff;
  atp_pkg::atp_pin_t     pin_ff;

  // Decoded strobes
  logic unit_on;
  logic wr_en;
  logic tick;
  logic m_start;
  logic s_start;
  logic m_stop;
  logic s_stop;
  logic m_wrap;
  logic m_start_int;
  logic s_reload;
  logic s_hit;

  function automatic logic reg_wr(input logic [7:0] ofs,
                                  input logic [7:0] addr,
                                  input logic       en);
    reg_wr = en && (addr == ofs);
  endfunction : reg_wr

  function automatic logic [PSC_W-1:0] psc_mask(
      input logic [atp_pkg::PSC_SEL_W-1:0] sel);
    logic [PSC_W:0] one_hot;
    one_hot  = (PSC_W+1)'(1) << sel;
    psc_mask = PSC_W'(one_hot - (PSC_W+1)'(1));
  endfunction : psc_mask

  assign unit_on = power_en_ff && clock_en_ff;
  assign wr_en   = PSEL_I && PENABLE_I && pready_ff && PWRITE_I;
  assign m_start = unit_on && PWDATA_I[atp_pkg::BIT_MASTER] &&
                   reg_wr(atp_pkg::OFS_START_TRIG, PADDR_I, wr_en);
  assign s_start = unit_on && PWDATA_I[atp_pkg::BIT_SLAVE] &&
                   reg_wr(atp_pkg::OFS_START_TRIG, PADDR_I, wr_en);
  assign m_stop  = unit_on && PWDATA_I[atp_pkg::BIT_MASTER] &&
                   reg_wr(atp_pkg::OFS_STOP_TRIG, PADDR_I, wr_en);
  assign s_stop  = unit_on && PWDATA_I[atp_pkg::BIT_SLAVE] &&
                   reg_wr(atp_pkg::OFS_STOP_TRIG, PADDR_I, wr_en);
  assign tick    = unit_on &&
                   ((psc_cnt_ff & psc_mask(psc_sel_ff)) ==
                    psc_mask(psc_sel_ff));
  assign m_wrap  = m_en_ff && !m_stop && !m_start && tick &&
                   (mcnt_ff == '0);
  assign m_start_int = m_start && mmode_ff[atp_pkg::BIT_START_INT];
  assign s_reload = s_en_ff && !s_stop && !s_start && m_wrap &&
                    up_phase_ff;
  assign s_hit   = s_en_ff && !s_stop && !s_start && tick && !s_reload &&
                   (slv_state_ff == atp_pkg::SLV_RUN) &&
                   (scnt_ff == CNT_W'(atp_pkg::SLAVE_HIT_VAL));

  // APB handshake, one wait-free access phase
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff <= PSEL_I && !PENABLE_I && !pready_ff;
      if (PSEL_I && !PENABLE_I) begin
        pslverr_ff <= nxt_unmapped;
        prdata_ff  <= PWRITE_I ? 32'h0000_0000 : nxt_prdata;
      end
    end
  end

  always_comb begin
    nxt_prdata   = 32'h0000_0000;
    nxt_unmapped = 1'b0;
    case (PADDR_I)
      atp_pkg::OFS_UNIT_CTRL: begin
        nxt_prdata[atp_pkg::BIT_POWER_EN] = power_en_ff;
        nxt_prdata[atp_pkg::BIT_CLOCK_EN] = clock_en_ff;
      end
      atp_pkg::OFS_PRESCALE:    nxt_prdata = 32'(psc_sel_ff);
      atp_pkg::OFS_MASTER_MODE: nxt_prdata = 32'(mmode_ff);
      atp_pkg::OFS_SLAVE_MODE:  nxt_prdata = 32'(smode_ff);
      atp_pkg::OFS_MASTER_DATA: nxt_prdata = 32'(mdata_ff);
      atp_pkg::OFS_SLAVE_DATA:  nxt_prdata = 32'(sdata_ff);
      atp_pkg::OFS_MASTER_CNT:  nxt_prdata = 32'(mcnt_ff);
      atp_pkg::OFS_SLAVE_CNT:   nxt_prdata = 32'(scnt_ff);
      atp_pkg::OFS_START_TRIG:  nxt_prdata = 32'h0000_0000;
      atp_pkg::OFS_STOP_TRIG:   nxt_prdata = 32'h0000_0000;
      atp_pkg::OFS_ENABLE_STAT: begin
        nxt_prdata[atp_pkg::BIT_MASTER] = m_en_ff;
        nxt_prdata[atp_pkg::BIT_SLAVE]  = s_en_ff;
      end
      atp_pkg::OFS_SLAVE_STAT: begin
        nxt_prdata[atp_pkg::BIT_UP_PHASE] = up_phase_ff;
        nxt_prdata[atp_pkg::BIT_HALTED] =
          (slv_state_ff == atp_pkg::SLV_HALT);
      end
      atp_pkg::OFS_OUT_CTRL: begin
        nxt_prdata[atp_pkg::BIT_OUT_ENABLE] = out_en_ff;
        nxt_prdata[atp_pkg::BIT_OUT_LEVEL]  = out_level_ff;
        nxt_prdata[atp_pkg::BIT_PORT_DIR]   = port_dir_ff;
        nxt_prdata[atp_pkg::BIT_PORT_LATCH] = port_latch_ff;
      end
      default: nxt_unmapped = 1'b1;
    endcase
  end

  // Unit enable and port bits, always writable
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      power_en_ff   <= 1'b0;
      clock_en_ff   <= 1'b0;
      port_dir_ff   <= 1'b0;
      port_latch_ff <= 1'b0;
    end else begin
      if (reg_wr(atp_pkg::OFS_UNIT_CTRL, PADDR_I, wr_en)) begin
        power_en_ff <= PWDATA_I[atp_pkg::BIT_POWER_EN];
        clock_en_ff <= PWDATA_I[atp_pkg::BIT_CLOCK_EN];
      end
      if (reg_wr(atp_pkg::OFS_OUT_CTRL, PADDR_I, wr_en)) begin
        port_dir_ff   <= PWDATA_I[atp_pkg::BIT_PORT_DIR];
        port_latch_ff <= PWDATA_I[atp_pkg::BIT_PORT_LATCH];
      end
    end
  end

  // Channel registers cleared while unit is off
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      psc_sel_ff <= '0;
      mmode_ff   <= '0;
      smode_ff   <= '0;
      mdata_ff   <= CNT_W'(atp_pkg::RST_DATA);
      sdata_ff   <= CNT_W'(atp_pkg::RST_DATA);
    end else if (!unit_on) begin
      psc_sel_ff <= '0;
      mmode_ff   <= '0;
      smode_ff   <= '0;
      mdata_ff   <= CNT_W'(atp_pkg::RST_DATA);
      sdata_ff   <= CNT_W'(atp_pkg::RST_DATA);
    end else begin
      if (reg_wr(atp_pkg::OFS_PRESCALE, PADDR_I, wr_en)) begin
        psc_sel_ff <= PWDATA_I[atp_pkg::PSC_SEL_W-1:0];
      end
      if (reg_wr(atp_pkg::OFS_MASTER_MODE, PADDR_I, wr_en)) begin
        mmode_ff <= PWDATA_I[atp_pkg::MODE_W-1:0];
      end
      if (reg_wr(atp_pkg::OFS_SLAVE_MODE, PADDR_I, wr_en)) begin
        smode_ff <= PWDATA_I[atp_pkg::MODE_W-1:0];
      end
      if (reg_wr(atp_pkg::OFS_MASTER_DATA, PADDR_I, wr_en)) begin
        mdata_ff <= PWDATA_I[CNT_W-1:0];
      end
      // Slave data used only at next start load or carrier reload
      if (reg_wr(atp_pkg::OFS_SLAVE_DATA, PADDR_I, wr_en)) begin
        sdata_ff <= PWDATA_I[CNT_W-1:0];
      end
    end
  end

  // Prescaler runs only while unit is on
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      psc_cnt_ff <= '0;
    end else if (!unit_on) begin
      psc_cnt_ff <= '0;
    end else begin
      psc_cnt_ff <= psc_cnt_ff + PSC_W'(1);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      m_en_ff <= 1'b0;
      s_en_ff <= 1'b0;
    end else if (!unit_on) begin
      m_en_ff <= 1'b0;
      s_en_ff <= 1'b0;
    end else begin
      if (m_stop) begin
        m_en_ff <= 1'b0;
      end else if (m_start) begin
        m_en_ff <= 1'b1;
      end
      if (s_stop) begin
        s_en_ff <= 1'b0;
      end else if (s_start) begin
        s_en_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mcnt_ff     <= '0;
      up_phase_ff <= 1'b0;
    end else if (!unit_on) begin
      mcnt_ff     <= '0;
      up_phase_ff <= 1'b0;
    end else if (m_start) begin
      mcnt_ff     <= mdata_ff;
      up_phase_ff <= 1'b0;
    end else if (m_wrap) begin
      mcnt_ff     <= mdata_ff;
      up_phase_ff <= !up_phase_ff;
    end else if (m_en_ff && !m_stop && tick) begin
      mcnt_ff <= mcnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mint_ff <= 1'b0;
    end else begin
      mint_ff <= m_start_int || m_wrap;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      scnt_ff      <= '0;
      slv_state_ff <= atp_pkg::SLV_IDLE;
    end else if (!unit_on) begin
      scnt_ff      <= '0;
      slv_state_ff <= atp_pkg::SLV_IDLE;
    end else if (s_stop) begin
      slv_state_ff <= atp_pkg::SLV_IDLE;
    end else if (s_start) begin
      slv_state_ff <= atp_pkg::SLV_LOAD;
    end else if (s_reload) begin
      scnt_ff      <= sdata_ff;
      slv_state_ff <= atp_pkg::SLV_RUN;
    end else if (s_en_ff && tick) begin
      case (slv_state_ff)
        atp_pkg::SLV_LOAD: begin
          scnt_ff      <= sdata_ff;
          slv_state_ff <= atp_pkg::SLV_RUN;
        end
        atp_pkg::SLV_RUN: begin
          if (s_hit) begin
            slv_state_ff <= atp_pkg::SLV_HALT;
          end else if (up_phase_ff) begin
            scnt_ff <= scnt_ff + CNT_W'(1);
          end else begin
            scnt_ff <= scnt_ff - CNT_W'(1);
          end
        end
        atp_pkg::SLV_HALT: slv_state_ff <= atp_pkg::SLV_HALT;
        default:           slv_state_ff <= atp_pkg::SLV_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= s_hit;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      out_en_ff    <= 1'b0;
      out_level_ff <= 1'b0;
    end else if (!unit_on) begin
      out_en_ff    <= 1'b0;
      out_level_ff <= 1'b0;
    end else if (reg_wr(atp_pkg::OFS_OUT_CTRL, PADDR_I, wr_en)) begin
      out_en_ff <= PWDATA_I[atp_pkg::BIT_OUT_ENABLE];
      if (!out_en_ff) begin
        out_level_ff <= PWDATA_I[atp_pkg::BIT_OUT_LEVEL];
      end else if (m_start_int || m_wrap) begin
        out_level_ff <= !out_level_ff;
      end
    end else if (out_en_ff && (m_start_int || m_wrap)) begin
      out_level_ff <= !out_level_ff;
    end
  end

  // Pin drive, port function when unit off
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_ff <= '0;
    end else begin
      pin_ff.oe  <= port_dir_ff;
      pin_ff.val <= port_latch_ff || (unit_on && out_level_ff);
    end
  end

  assign PRDATA_O     = prdata_ff;
  assign PREADY_O     = pready_ff;
  assign PSLVERR_O    = pslverr_ff;
  assign MASTER_INT_O = mint_ff;
  assign ADC_TRIG_O   = trig_ff;
  assign MASTER_PIN_O = pin_ff;

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  start_sets_en_a: assert property (
    (m_start && !m_stop) |=> m_en_ff ##0 (mcnt_ff == $past(mdata_ff)))
    else $error("master start did not enable and load");
  stop_freezes_a: assert property (
    (m_stop && unit_on) |=> (!m_en_ff && $stable(mcnt_ff)) [*2])
    else $error("stop did not freeze master");
  wrap_reload_a: assert property (
    m_wrap |=> (mcnt_ff == $past(mdata_ff)) && MASTER_INT_O &&
               (up_phase_ff != $past(up_phase_ff)))
    else $error("master wrap wrong");
  no_start_int_a: assert property (
    (m_start && !mmode_ff[atp_pkg::BIT_START_INT]) |=> !MASTER_INT_O)
    else $error("start interrupt without select");
  slave_hit_a: assert property (
    s_hit |=> ADC_TRIG_O && (slv_state_ff == atp_pkg::SLV_HALT) ##1
              !ADC_TRIG_O)
    else $error("slave trigger or halt wrong");
  slave_reload_a: assert property (
    s_reload |=> (scnt_ff == $past(sdata_ff)) &&
                 (slv_state_ff == atp_pkg::SLV_RUN))
    else $error("slave reload wrong");
  tick_only_a: assert property (
    (!tick && !m_start) |=> $stable(mcnt_ff) || !$past(unit_on))
    else $error("master moved without tick");
  unit_off_a: assert property (
    !unit_on |=> (mcnt_ff == '0) && !m_en_ff && !out_level_ff &&
                 !s_en_ff)
    else $error("unit off did not clear timer");
  pin_level_a: assert property (
    (unit_on && port_dir_ff && !port_latch_ff) |=>
      MASTER_PIN_O.oe && (MASTER_PIN_O.val == $past(out_level_ff)))
    else $error("pin does not show master level");

  start_cov_c:  cover property (m_start && s_start);
  trig_cov_c:   cover property (s_hit);
  reload_cov_c: cover property (s_reload ##[1:200] s_hit);
  stop_cov_c:   cover property (m_stop && s_stop && m_en_ff);

endmodule : atp_top

// File: test/atp_adc_model.sv
/*
  Behavioural A/D converter trigger input that counts conversion starts.
  Assumes the trigger is a one-cycle pulse on the bench clock.
*/
`timescale 1ns/10ps
module atp_adc_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Conversion trigger
  input  wire logic trig_i,
  // Conversions seen
  output int        conv_count_o
);
  logic trig_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q       <= 1'b0;
      conv_count_o <= 0;
    end else begin
      trig_q <= trig_i;
      if (trig_i === 1'b1 && trig_q !== 1'b1) begin
        conv_count_o <= conv_count_o + 1;
      end
    end
  end
endmodule : atp_adc_model

// File: test/test_adc_trigger_timer_pair.sv
/*
  Self-checking bench for the A/D trigger timer pair.
  Assumes the zero-wait APB slave and pulse timing of atp_top.
*/
`timescale 1ns/10ps
module test_adc_trigger_timer_pair;
  logic              clk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              mint;
  logic              trig;
  atp_pkg::atp_pin_t pin;
  int                failures;
  int                num_checks;
  int                cyc;
  int                tot_trig;
  int                conv_count;
  int                mq[$];
  int                aq[$];
  logic [31:0]       rd;
  logic              err;

  atp_top #(.CNT_W(16), .PSC_W(16)) dut_u (
    .REF_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MASTER_INT_O(mint), .ADC_TRIG_O(trig), .MASTER_PIN_O(pin)
  );

  atp_adc_model adc_u (
    .clk_i(clk), .nrst_i(nrst), .trig_i(trig), .conv_count_o(conv_count)
  );

  always #2 clk = ~clk;

  task automatic chk_word(input string nm, input logic [31:0] exp,
                          input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_int(input string nm, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_int

  task automatic final_report;
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr32

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(nm, exp, rd);
    chk_word("slverr", 32'h0, {31'h0, err});
  endtask : rdchk

  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic wait_trig(input int n);
    while (aq.size() < n) begin
      @(posedge clk);
    end
  endtask : wait_trig

  function automatic int prev_int(input int t);
    int r;
    r = 0;
    foreach (mq[i]) begin
      if (mq[i] < t) begin
        r = mq[i];
      end
    end
    return r;
  endfunction : prev_int

  always @(posedge clk) begin
    cyc++;
    if (mint === 1'b1) begin
      mq.push_back(cyc);
    end
    if (trig === 1'b1) begin
      aq.push_back(cyc);
      tot_trig++;
      chk_word("pin_at_trig", 32'h1, {31'h0, pin.val});
    end
  end

  task automatic run_case(input logic md, input logic [3:0] ps,
                          input int m, input int s1, input int s2);
    int   t0;
    int   mc;
    int   nint;
    int   d1;
    int   d2;
    logic lvl;
    logic pv;
    lvl = ~md;
    wr32(atp_pkg::OFS_PRESCALE, {28'h0, ps});
    wr32(atp_pkg::OFS_MASTER_MODE, {31'h0, md});
    wr32(atp_pkg::OFS_SLAVE_MODE, 32'h0);
    wr32(atp_pkg::OFS_MASTER_DATA, m);
    wr32(atp_pkg::OFS_SLAVE_DATA, s1);
    wr32(atp_pkg::OFS_OUT_CTRL, 32'h4);
    wr32(atp_pkg::OFS_OUT_CTRL, {29'h0, 1'b1, lvl, 1'b0});
    settle();
    chk_word("pin_default", {31'h0, lvl}, {31'h0, pin.val});
    wr32(atp_pkg::OFS_OUT_CTRL, {29'h0, 1'b1, lvl, 1'b1});
    mq.delete();
    aq.delete();
    t0 = cyc;
    wr32(atp_pkg::OFS_START_TRIG, 32'h3);
    rdchk("enable_stat", atp_pkg::OFS_ENABLE_STAT, 32'h3);
    rdchk("start_trig", atp_pkg::OFS_START_TRIG, 32'h0);
    wait_trig(3);
    apb(1'b0, atp_pkg::OFS_SLAVE_STAT, 32'h0);
    chk_int("slave_halted", 1, int'(rd[atp_pkg::BIT_HALTED]));
    apb(1'b0, atp_pkg::OFS_MASTER_CNT, 32'h0);
    chk_int("mcnt_range", 1, int'(rd <= m));
    wr32(atp_pkg::OFS_SLAVE_DATA, s2);
    wait_trig(7);
    wr32(atp_pkg::OFS_STOP_TRIG, 32'h3);
    rdchk("enable_stat", atp_pkg::OFS_ENABLE_STAT, 32'h0);
    apb(1'b0, atp_pkg::OFS_MASTER_CNT, 32'h0);
    mc = rd;
    nint = mq.size();
    settle();
    pv = pin.val;
    repeat (10) @(posedge clk);
    rdchk("mcnt_frozen", atp_pkg::OFS_MASTER_CNT, mc);
    chk_int("no_int_stopped", nint, mq.size());
    chk_word("pin_held", {31'h0, pv}, {31'h0, pin.val});
    chk_int("start_int", md, int'(mq[0] - t0 <= 6));
    chk_int("mint_period", (m + 1) << ps, mq[2] - mq[1]);
    chk_int("mint_period", (m + 1) << ps, mq[3] - mq[2]);
    chk_int("carrier", (2 * (m + 1)) << ps, aq[2] - aq[1]);
    chk_int("carrier", (2 * (m + 1)) << ps, aq[6] - aq[5]);
    d1 = aq[1] - prev_int(aq[1]);
    d2 = aq[6] - prev_int(aq[6]);
    chk_int("trig_in_down", 1, int'(d1 > 0 && d1 < ((m + 1) << ps)));
    chk_int("trig_shift", (s2 - s1) << ps, d2 - d1);
  endtask : run_case

  initial begin
    int          m;
    int          s1;
    int          s2;
    logic [31:0] rv;
    logic        lvl;
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    tot_trig = 0;
    rv = $urandom(32'h6ab239dd);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_word("outs_rst", 32'h0,
             {27'h0, pready, pslverr, mint, trig, pin.val});
    wr32(atp_pkg::OFS_MASTER_DATA, 32'h5a);
    rdchk("data_off", atp_pkg::OFS_MASTER_DATA, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk_word("unmapped", 32'h1, {31'h0, err});
    chk_word("unmapped_rd", 32'h0, rd);
    wr32(atp_pkg::OFS_UNIT_CTRL, 32'h3);
    rdchk("stopped_on", atp_pkg::OFS_ENABLE_STAT, 32'h0);
    rv = $urandom;
    wr32(atp_pkg::OFS_MASTER_DATA, rv);
    rdchk("mdata", atp_pkg::OFS_MASTER_DATA, {16'h0, rv[15:0]});
    for (int k = 0; k < 3; k++) begin
      m = 4 + $urandom % 8;
      s1 = 1 + $urandom % (m - 1);
      s2 = (k == 0) ? 1 : 1 + $urandom % m;
      run_case(k == 0, (k == 2) ? 4'h1 : 4'h0, m, s1, s2);
    end
    lvl = ~pin.val;
    wr32(atp_pkg::OFS_OUT_CTRL, 32'h4);
    wr32(atp_pkg::OFS_OUT_CTRL, {29'h0, 1'b1, lvl, 1'b0});
    settle();
    chk_word("pin_level", {31'h0, lvl}, {31'h0, pin.val});
    wr32(atp_pkg::OFS_OUT_CTRL, {28'h0, lvl, 1'b1, lvl, 1'b0});
    wr32(atp_pkg::OFS_OUT_CTRL, {28'h0, lvl, 3'b100});
    settle();
    chk_word("pin_latch", {30'h0, lvl, 1'b1}, {30'h0, pin});
    wr32(atp_pkg::OFS_OUT_CTRL, {28'h0, lvl, 3'b000});
    settle();
    chk_word("pin_input", 32'h0, {31'h0, pin.oe});
    wr32(atp_pkg::OFS_OUT_CTRL, {28'h0, lvl, 3'b110});
    wr32(atp_pkg::OFS_UNIT_CTRL, 32'h0);
    rdchk("out_off", atp_pkg::OFS_OUT_CTRL, {28'h0, lvl, 3'b100});
    rdchk("mdata_off", atp_pkg::OFS_MASTER_DATA, 32'h0);
    settle();
    chk_word("pin_off", {31'h0, lvl}, {31'h0, pin.val});
    chk_int("conv_count", tot_trig, conv_count);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : test_adc_trigger_timer_pair
